//--- rtl/ims_master.sv
// Purpose: I2C master sequencer with a Wishbone register port
// Assumes: Open-drain pins, enable high pulls the line low
// Notes:   Sequences are strictly one at a time; nothing is queued
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ims_master
   import ims_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Line sampling and rate generator
   logic [1:0] lines;
   logic       scl_s;
   logic       sda_s;
   logic       tick;
   logic       brg_en;
   ims_state_t state_r;
   ims_state_t state_nxt;
   logic [7:0] reload_r;
   logic [7:0] reload_nxt;

   ims_sync u_sync (
      .clock (clock),
      .rstn  (rstn),
      .d_in  ({scl_i, sda_i}),
      .q_out (lines)
   );
   assign scl_s = lines[1];
   assign sda_s = lines[0];

   // Generator runs only in timed phases; wait phases hold it at reload
   assign brg_en = (state_r == IMS_S_CHK) || (state_r == IMS_S_HOLD)
                || (state_r == IMS_R_SDA) || (state_r == IMS_R_HIGH)
                || (state_r == IMS_R_SDAL) || (state_r == IMS_T_LOW)
                || (state_r == IMS_T_HIGH) || (state_r == IMS_V_LOW)
                || (state_r == IMS_V_HIGH) || (state_r == IMS_A_LOW)
                || (state_r == IMS_A_HIGH) || (state_r == IMS_P_LOW)
                || (state_r == IMS_P_HIGH) || (state_r == IMS_P_END);

   ims_brg u_brg (
      .clock  (clock),
      .rstn   (rstn),
      .en     (brg_en),
      .reload (reload_r),
      .tick   (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave decode
   logic        acc;
   logic        wr;
   logic        rd;
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic        busy;
   logic [5:0]  ctrl_rd;
   logic [7:0]  stat_rd;

   // Access completes at the edge where ack is high
   assign acc = wb_cyc_i && wb_stb_i && ack_r;
   assign wr  = acc && wb_we_i && wb_sel_i[0];
   assign rd  = acc && !wb_we_i;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   logic [5:0] ctrl_r;
   logic [5:0] ctrl_nxt;
   logic [5:0] flag_r;
   logic [5:0] flag_nxt;
   logic [5:0] flag_set;
   logic [7:0] xbuf_r;
   logic [7:0] xbuf_nxt;
   logic [7:0] sreg_r;
   logic [7:0] sreg_nxt;
   logic [3:0] bit_r;
   logic [3:0] bit_nxt;
   logic       bf_r;
   logic       bf_nxt;
   logic       ackst_r;
   logic       ackst_nxt;
   logic       scl_drv_r;
   logic       scl_drv_nxt;
   logic       sda_drv_r;
   logic       sda_drv_nxt;

   assign busy = (state_r != IMS_IDLE) || (ctrl_r[IMS_C_ACKSEQ:IMS_C_START] != 5'h00);
   assign ctrl_rd = ctrl_r;
   assign stat_rd = {ackst_r, bf_r, flag_r};

   always_comb begin
      state_nxt   = state_r;
      ctrl_nxt    = ctrl_r;
      flag_set    = 6'h00;
      xbuf_nxt    = xbuf_r;
      sreg_nxt    = sreg_r;
      bit_nxt     = bit_r;
      bf_nxt      = bf_r;
      ackst_nxt   = ackst_r;
      scl_drv_nxt = scl_drv_r;
      sda_drv_nxt = sda_drv_r;
      reload_nxt  = reload_r;

      // Register writes
      if (wr && wb_adr_i == IMS_ADR_RELOAD) begin
         reload_nxt = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == IMS_ADR_CTRL) begin
         ctrl_nxt[IMS_C_ACKDATA] = wb_dat_i[IMS_C_ACKDATA];
         if (!busy) begin
            ctrl_nxt[IMS_C_ACKSEQ:IMS_C_START] = wb_dat_i[IMS_C_ACKSEQ:IMS_C_START];
         end
      end
      if (rd && wb_adr_i == IMS_ADR_BUF && !busy) begin
         bf_nxt = 1'b0;
      end
      if (wr && wb_adr_i == IMS_ADR_BUF && busy) begin
         flag_set[IMS_S_WRITE_COLLISION_FLAG] = 1'b1;
      end

      case (state_r)
         IMS_IDLE: begin
            if (wr && wb_adr_i == IMS_ADR_BUF) begin
               if (!busy) begin
                  xbuf_nxt    = wb_dat_i[7:0];
                  sreg_nxt    = wb_dat_i[7:0];
                  bf_nxt      = 1'b1;
                  bit_nxt     = 4'h0;
                  scl_drv_nxt = 1'b1;
                  state_nxt   = IMS_T_LOW;
               end
            end else if (ctrl_r[IMS_C_START]) begin
               if (scl_s && sda_s) begin
                  state_nxt = IMS_S_CHK;
               end else begin
                  flag_set[IMS_S_COLL]  = 1'b1;
                  ctrl_nxt[IMS_C_START] = 1'b0;
               end
            end else if (ctrl_r[IMS_C_RESTART]) begin
               scl_drv_nxt = 1'b1;
               state_nxt   = IMS_R_LOW;
            end else if (ctrl_r[IMS_C_STOP]) begin
               scl_drv_nxt = 1'b1;
               sda_drv_nxt = 1'b1;
               state_nxt   = IMS_P_SDAL;
            end else if (ctrl_r[IMS_C_ACKSEQ]) begin
               scl_drv_nxt = 1'b1;
               state_nxt   = IMS_A_LOW;
            end else if (ctrl_r[IMS_C_RECV]) begin
               scl_drv_nxt = 1'b1;
               sda_drv_nxt = 1'b0;
               bit_nxt     = 4'h0;
               state_nxt   = IMS_V_LOW;
            end
         end
         IMS_S_CHK: begin
            if (!scl_s || !sda_s) begin
               flag_set[IMS_S_COLL]  = 1'b1;
               ctrl_nxt[IMS_C_START] = 1'b0;
               state_nxt             = IMS_IDLE;
            end else if (tick) begin
               sda_drv_nxt               = 1'b1;
               flag_set[IMS_S_STARTDET]  = 1'b1;
               state_nxt                 = IMS_S_HOLD;
            end
         end
         IMS_S_HOLD: begin
            if (tick) begin
               ctrl_nxt[IMS_C_START] = 1'b0;
               flag_set[IMS_S_EVENT] = 1'b1;
               state_nxt             = IMS_IDLE;
            end
         end
         IMS_R_LOW: begin
            if (!scl_s) begin
               sda_drv_nxt = 1'b0;
               state_nxt   = IMS_R_SDA;
            end
         end
         IMS_R_SDA: begin
            if (tick) begin
               if (sda_s) begin
                  scl_drv_nxt = 1'b0;
                  state_nxt   = IMS_R_SCLH;
               end else begin
                  flag_set[IMS_S_COLL] = 1'b1;
                  scl_drv_nxt          = 1'b0;
                  ctrl_nxt             = ctrl_r & 6'h20;
                  state_nxt            = IMS_IDLE;
               end
            end
         end
         IMS_R_SCLH: begin
            if (scl_s) begin
               if (!sda_s) begin
                  flag_set[IMS_S_COLL] = 1'b1;
                  ctrl_nxt             = ctrl_r & 6'h20;
                  state_nxt            = IMS_IDLE;
               end else begin
                  state_nxt = IMS_R_HIGH;
               end
            end
         end
         IMS_R_HIGH: begin
            if (!scl_s) begin
               flag_set[IMS_S_COLL] = 1'b1;
               ctrl_nxt             = ctrl_r & 6'h20;
               state_nxt            = IMS_IDLE;
            end else if (tick) begin
               sda_drv_nxt = 1'b1;
               state_nxt   = IMS_R_SDAL;
            end
         end
         IMS_R_SDAL: begin
            if (scl_s && !sda_s) begin
               flag_set[IMS_S_STARTDET] = 1'b1;
            end
            if (tick) begin
               scl_drv_nxt             = 1'b1;
               ctrl_nxt[IMS_C_RESTART] = 1'b0;
               flag_set[IMS_S_EVENT]   = 1'b1;
               state_nxt               = IMS_IDLE;
            end
         end
         IMS_T_LOW: begin
            // Data moves one clock after SCL is pulled low
            sda_drv_nxt = (bit_r == IMS_ACK_BIT) ? 1'b0 : !sreg_r[7];
            if (tick) begin
               scl_drv_nxt = 1'b0;
               state_nxt   = IMS_T_SCLH;
            end
         end
         IMS_T_SCLH: begin
            if (scl_s) begin
               if (bit_r == IMS_ACK_BIT) begin
                  ackst_nxt = sda_s;
               end
               state_nxt = IMS_T_HIGH;
            end
         end
         IMS_T_HIGH: begin
            if (tick) begin
               scl_drv_nxt = 1'b1;
               if (bit_r == IMS_ACK_BIT) begin
                  flag_set[IMS_S_EVENT] = 1'b1;
                  state_nxt             = IMS_IDLE;
               end else begin
                  if (bit_r == IMS_LAST_BIT) begin
                     bf_nxt = 1'b0;
                  end
                  sreg_nxt  = {sreg_r[6:0], 1'b0};
                  bit_nxt   = bit_r + 4'h1;
                  state_nxt = IMS_T_LOW;
               end
            end
         end
         IMS_V_LOW: begin
            if (tick) begin
               scl_drv_nxt = 1'b0;
               state_nxt   = IMS_V_SCLH;
            end
         end
         IMS_V_SCLH: begin
            if (scl_s) begin
               state_nxt = IMS_V_HIGH;
            end
         end
         IMS_V_HIGH: begin
            if (tick) begin
               scl_drv_nxt = 1'b1;
               sreg_nxt    = {sreg_r[6:0], sda_s};
               if (bit_r == IMS_LAST_BIT) begin
                  ctrl_nxt[IMS_C_RECV]  = 1'b0;
                  xbuf_nxt              = {sreg_r[6:0], sda_s};
                  bf_nxt                = 1'b1;
                  flag_set[IMS_S_EVENT] = 1'b1;
                  flag_set[IMS_S_ROV]   = bf_r;
                  state_nxt             = IMS_IDLE;
               end else begin
                  bit_nxt   = bit_r + 4'h1;
                  state_nxt = IMS_V_LOW;
               end
            end
         end
         IMS_A_LOW: begin
            sda_drv_nxt = !ctrl_r[IMS_C_ACKDATA];
            if (tick) begin
               scl_drv_nxt = 1'b0;
               state_nxt   = IMS_A_SCLH;
            end
         end
         IMS_A_SCLH: begin
            if (scl_s) begin
               state_nxt = IMS_A_HIGH;
            end
         end
         IMS_A_HIGH: begin
            if (tick) begin
               scl_drv_nxt            = 1'b1;
               ctrl_nxt[IMS_C_ACKSEQ] = 1'b0;
               flag_set[IMS_S_EVENT]  = 1'b1;
               state_nxt              = IMS_IDLE;
            end
         end
         IMS_P_SDAL: begin
            if (!sda_s) begin
               state_nxt = IMS_P_LOW;
            end
         end
         IMS_P_LOW: begin
            if (tick) begin
               scl_drv_nxt = 1'b0;
               state_nxt   = IMS_P_SCLH;
            end
         end
         IMS_P_SCLH: begin
            if (scl_s) begin
               state_nxt = IMS_P_HIGH;
            end
         end
         IMS_P_HIGH: begin
            if (tick) begin
               sda_drv_nxt = 1'b0;
               state_nxt   = IMS_P_SDAH;
            end
         end
         IMS_P_SDAH: begin
            if (sda_s && scl_s) begin
               flag_set[IMS_S_STOPDET] = 1'b1;
               state_nxt               = IMS_P_END;
            end
         end
         IMS_P_END: begin
            if (tick) begin
               ctrl_nxt[IMS_C_STOP]  = 1'b0;
               flag_set[IMS_S_EVENT] = 1'b1;
               state_nxt             = IMS_IDLE;
            end
         end
         default: begin
            state_nxt   = IMS_IDLE;
            scl_drv_nxt = 1'b0;
            sda_drv_nxt = 1'b0;
         end
      endcase

      // Any bus collision lets both lines go; a write collision leaves them as they are
      if (flag_set[IMS_S_COLL]) begin
         scl_drv_nxt = 1'b0;
         sda_drv_nxt = 1'b0;
      end

      // Write-one-to-clear; a set in the same cycle wins
      flag_nxt = flag_r;
      if (wr && wb_adr_i == IMS_ADR_STAT) begin
         flag_nxt = flag_r & ~wb_dat_i[5:0];
      end
      flag_nxt = flag_nxt | flag_set;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r   <= IMS_IDLE;
         ctrl_r    <= 6'h00;
         flag_r    <= 6'h00;
         xbuf_r    <= 8'h00;
         sreg_r    <= 8'h00;
         bit_r     <= 4'h0;
         bf_r      <= 1'b0;
         ackst_r   <= 1'b0;
         scl_drv_r <= 1'b0;
         sda_drv_r <= 1'b0;
         reload_r  <= IMS_RELOAD_RST;
      end else begin
         state_r   <= state_nxt;
         ctrl_r    <= ctrl_nxt;
         flag_r    <= flag_nxt;
         xbuf_r    <= xbuf_nxt;
         sreg_r    <= sreg_nxt;
         bit_r     <= bit_nxt;
         bf_r      <= bf_nxt;
         ackst_r   <= ackst_nxt;
         scl_drv_r <= scl_drv_nxt;
         sda_drv_r <= sda_drv_nxt;
         reload_r  <= reload_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, read data registered with ack
   always_comb begin
      ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
      dat_nxt = 32'h0000_0000;
      if (ack_nxt && !wb_we_i) begin
         case (wb_adr_i)
            IMS_ADR_CTRL:   dat_nxt = {26'h000_0000, ctrl_rd};
            IMS_ADR_STAT:   dat_nxt = {24'h00_0000, stat_rd};
            IMS_ADR_BUF:    dat_nxt = {24'h00_0000, xbuf_r};
            IMS_ADR_RELOAD: dat_nxt = {24'h00_0000, reload_r};
            default:        dat_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe   = scl_drv_r;
   assign sda_oe   = sda_drv_r;
endmodule : ims_master
`default_nettype wire

//--- rtl/ims_pkg.sv
// Purpose: Constants, register map and state codes of the I2C master sequencer
// Assumes: Classic Wishbone slave, 32-bit data, one word per register
// Notes:   Register field lists below
package ims_pkg;
   localparam logic [4:0] IMS_ADR_CTRL   = 5'h00;
   localparam logic [4:0] IMS_ADR_STAT   = 5'h04;
   localparam logic [4:0] IMS_ADR_BUF    = 5'h08;
   localparam logic [4:0] IMS_ADR_RELOAD = 5'h0C;
   // Control register fields
   localparam int IMS_C_START = 0;
   localparam int IMS_C_RESTART = 1;
   localparam int IMS_C_STOP = 2;
   localparam int IMS_C_RECV = 3;
   localparam int IMS_C_ACKSEQ = 4;
   localparam int IMS_C_ACKDATA = 5;
   // Status register fields
   localparam int IMS_S_EVENT = 0;
   localparam int IMS_S_COLL = 1;
   localparam int IMS_S_WRITE_COLLISION_FLAG = 2;
   localparam int IMS_S_ROV = 3;
   localparam int IMS_S_STARTDET = 4;
   localparam int IMS_S_STOPDET = 5;
   localparam int IMS_S_BFULL = 6;
   localparam int IMS_S_SLAVE_ACK_STATUS = 7;
   localparam logic [7:0] IMS_RELOAD_RST = 8'h04;
   localparam logic [3:0] IMS_LAST_BIT = 4'h7;
   localparam logic [3:0] IMS_ACK_BIT = 4'h8;
   typedef enum logic [22:0] {
      IMS_IDLE   = 23'h00_0001,
      IMS_S_CHK  = 23'h00_0002,
      IMS_S_HOLD = 23'h00_0004,
      IMS_R_LOW  = 23'h00_0008,
      IMS_R_SDA  = 23'h00_0010,
      IMS_R_SCLH = 23'h00_0020,
      IMS_R_HIGH = 23'h00_0040,
      IMS_R_SDAL = 23'h00_0080,
      IMS_T_LOW  = 23'h00_0100,
      IMS_T_SCLH = 23'h00_0200,
      IMS_T_HIGH = 23'h00_0400,
      IMS_V_LOW  = 23'h00_0800,
      IMS_V_SCLH = 23'h00_1000,
      IMS_V_HIGH = 23'h00_2000,
      IMS_A_LOW  = 23'h00_4000,
      IMS_A_SCLH = 23'h00_8000,
      IMS_A_HIGH = 23'h01_0000,
      IMS_P_SDAL = 23'h02_0000,
      IMS_P_LOW  = 23'h04_0000,
      IMS_P_SCLH = 23'h08_0000,
      IMS_P_HIGH = 23'h10_0000,
      IMS_P_SDAH = 23'h20_0000,
      IMS_P_END  = 23'h40_0000
   } ims_state_t;
endpackage : ims_pkg

//--- rtl/ims_sync.sv
// Purpose: Two-stage synchroniser for the sampled bus lines
// Assumes: Inputs are asynchronous pin levels
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module ims_sync (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic [1:0] d_in,
   output logic      [1:0] q_out
);
   logic [1:0] meta_r;
   logic [1:0] q_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_r <= 2'h3;
         q_r    <= 2'h3;
      end else begin
         meta_r <= d_in;
         q_r    <= meta_r;
      end
   end
   assign q_out = q_r;
endmodule : ims_sync
`default_nettype wire

//--- rtl/ims_brg.sv
// Purpose: Reloadable rate generator, one tick per period
// Assumes: Period is reload plus one clocks
// Notes:   Held at reload while disabled, so enabling starts a fresh period
`timescale 1ns/10ps
`default_nettype none
module ims_brg (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       en,
   input  wire logic [7:0] reload,
   output logic            tick
);
   import ims_pkg::*;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   always_comb begin
      if (!en || cnt_r == 8'h00) begin
         cnt_nxt = reload;
      end else begin
         cnt_nxt = cnt_r - 8'h01;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= IMS_RELOAD_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign tick = en && (cnt_r == 8'h00);
endmodule : ims_brg
`default_nettype wire

//--- testbench/ims_slave_model.sv
// Purpose: Behavioural I2C slave facing the sequencer
// Assumes: Wires pulled up; a pull output high drags its wire low
// Notes:   Bit count restarts on any start seen on the wires
`timescale 1ns/10ps
`default_nettype none
module ims_slave_model (
   input  wire logic       scl_w,
   input  wire logic       sda_w,
   input  wire logic       ack_low,
   input  wire logic       rd_mode,
   input  wire logic       hold_sda,
   input  wire logic [7:0] tx_byte,
   input  wire logic [9:0] stretch_ns,
   output logic            scl_pull,
   output logic            sda_pull,
   output logic [7:0]      rx_byte
);
   int         cnt = 0;
   logic [7:0] sh = 8'h00;
   logic       drv = 1'b0;
   initial scl_pull = 1'b0;
   initial rx_byte = 8'h00;
   assign sda_pull = drv || hold_sda;
   always @(negedge sda_w) if (scl_w) cnt = 0;
   // A stop frees the data line so the bus can idle
   always @(posedge sda_w) if (scl_w) drv = 1'b0;
   always @(posedge scl_w) begin
      if (cnt < 8) sh = {sh[6:0], sda_w};
      if (cnt == 7) rx_byte = sh;
      cnt = (cnt == 8) ? 0 : cnt + 1;
   end
   // Data only moves while SCL is low
   always @(negedge scl_w or rd_mode) begin
      if (rd_mode) drv = (cnt < 8) && !tx_byte[7 - cnt];
      else drv = (cnt == 8) && ack_low;
   end
   // Stretching makes the master wait for the real SCL level
   always @(negedge scl_w) if (stretch_ns != 10'h000) begin
      scl_pull = 1'b1;
      #(stretch_ns) scl_pull = 1'b0;
   end
endmodule : ims_slave_model
`default_nettype wire

//--- testbench/ims_master_checker.sv
// Purpose: Port checker for ims_master
// Assumes: scl_i and sda_i carry the resolved wire levels
// Notes:   Tracks reload writes to bound the SCL high time
`timescale 1ns/10ps
`default_nettype none
module ims_master_checker
   import ims_pkg::*;
(
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe
);
   logic [7:0] rl_r, rl_nxt;
   logic [9:0] hi_r, hi_nxt;
   always_comb begin
      rl_nxt = rl_r;
      if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == IMS_ADR_RELOAD) rl_nxt = wb_dat_i[7:0];
      hi_nxt = (scl_i && !scl_oe) ? hi_r + {9'h000, ~&hi_r} : 10'h000;
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rl_r <= IMS_RELOAD_RST;
         hi_r <= 10'h000;
      end else begin
         rl_r <= rl_nxt;
         hi_r <= hi_nxt;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   ack_wait_a: assert property (req_s |=> wb_ack_o) else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > IMS_ADR_RELOAD
      |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
   open_drain_a: assert property (!scl_o && !sda_o) else $error("pin drives high");
   start_edge_a: assert property ($rose(sda_oe) && !scl_oe |-> scl_i)
      else $error("SDA pulled while SCL low");
   stop_release_a: assert property ($fell(sda_oe) && !scl_oe |-> scl_i)
      else $error("SDA freed while SCL low");
   scl_high_a: assert property ($rose(scl_oe) |-> hi_r > {2'b00, rl_r})
      else $error("SCL high time short");
endmodule : ims_master_checker
`default_nettype wire

//--- testbench/i2c_master_sequencer_test.sv
// Purpose: Self-checking bench for the I2C master sequencer
// Assumes: Reload 15 keeps a byte near 315 clocks
// Notes:   Slave model gives ack, read data and stretching
`timescale 1ns/10ps
`default_nettype none
module i2c_master_sequencer_test
   import ims_pkg::*;
();
   localparam logic [31:0] EV = 32'h0000_0001 << IMS_S_EVENT;
   localparam logic [31:0] CO = 32'h0000_0001 << IMS_S_COLL;
   localparam logic [31:0] WC = 32'h0000_0001 << IMS_S_WRITE_COLLISION_FLAG;
   localparam logic [31:0] RO = 32'h0000_0001 << IMS_S_ROV;
   localparam logic [31:0] SD = 32'h0000_0001 << IMS_S_STARTDET;
   localparam logic [31:0] PD = 32'h0000_0001 << IMS_S_STOPDET;
   localparam logic [31:0] BF = 32'h0000_0001 << IMS_S_BFULL;
   localparam logic [31:0] AK = 32'h0000_0001 << IMS_S_SLAVE_ACK_STATUS;
   logic        clock, rstn, cyc, stb, we, ack, ack_low, rd_mode, hold_sda;
   logic        scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, dout, q;
   logic [7:0]  tx_byte, rx_byte, b;
   logic [9:0]  stretch_ns;
   logic [7:0]  sent_q[$];
   int          n_mismatch = 0, n_tests = 0, cycles = 0, seed;
   wire         scl_w = !(scl_oe || scl_pull);
   wire         sda_w = !(sda_oe || sda_pull);
   ims_master dut_u (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
      .wb_ack_o(ack), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe));
   ims_slave_model slave_u (.scl_w(scl_w), .sda_w(sda_w), .ack_low(ack_low),
      .rd_mode(rd_mode), .hold_sda(hold_sda), .tx_byte(tx_byte), .stretch_ns(stretch_ns),
      .scl_pull(scl_pull), .sda_pull(sda_pull), .rx_byte(rx_byte));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n == 20) n_mismatch++;
      q = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask : rd
   task automatic wait_ev(input int bi);
      int n;
      n = 0;
      do begin
         bus(1'b0, IMS_ADR_STAT, 32'h0000_0000);
         n++;
      end while (q[bi] !== 1'b1 && n < 400);
      if (n == 400) n_mismatch++;
   endtask : wait_ev
   task automatic send(input logic nack);
      b = 8'($random(seed));
      sent_q.push_back(b);
      bus(1'b1, IMS_ADR_BUF, {24'h00_0000, b});
      rd(IMS_ADR_STAT, BF | (ack_low ? 32'h0000_0000 : AK), "status busy");
      ack_low = !nack;
      bus(1'b1, IMS_ADR_BUF, {24'h00_0000, ~b});
      wait_ev(IMS_S_EVENT);
      chk("status sent", EV | WC | (nack ? AK : 32'h0000_0000), q);
      chk("slave byte", {24'h00_0000, sent_q.pop_front()}, {24'h00_0000, rx_byte});
      bus(1'b1, IMS_ADR_STAT, 32'h0000_00ff);
   endtask : send
   initial begin
      seed = 32'hdf08_e34e;
      {rstn, cyc, stb, we, rd_mode, hold_sda, adr, dat} = '0;
      {sel, ack_low, tx_byte, stretch_ns} = {4'hf, 1'b1, 8'h00, 10'h000};
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd(IMS_ADR_CTRL, 32'h0000_0000, "ctrl reset");
      rd(IMS_ADR_STAT, 32'h0000_0000, "status reset");
      rd(IMS_ADR_BUF, 32'h0000_0000, "buffer reset");
      rd(IMS_ADR_RELOAD, {24'h00_0000, IMS_RELOAD_RST}, "reload reset");
      rd({1'b1, 4'($random(seed))}, 32'h0000_0000, "unmapped");
      bus(1'b1, IMS_ADR_RELOAD, 32'h0000_000f);
      hold_sda = 1'b1;
      bus(1'b1, IMS_ADR_CTRL, 32'h0000_0001);
      wait_ev(IMS_S_COLL);
      chk("start collision", CO, q);
      rd(IMS_ADR_CTRL, 32'h0000_0000, "ctrl aborted");
      hold_sda = 1'b0;
      bus(1'b1, IMS_ADR_STAT, 32'h0000_00ff);
      bus(1'b1, IMS_ADR_CTRL, 32'h0000_0001);
      bus(1'b1, IMS_ADR_CTRL, 32'h0000_000a);
      rd(IMS_ADR_CTRL, 32'h0000_0001, "ctrl in start");
      bus(1'b1, IMS_ADR_BUF, 32'($random(seed)));
      wait_ev(IMS_S_EVENT);
      chk("start done", EV | SD | WC, q);
      rd(IMS_ADR_CTRL, 32'h0000_0000, "ctrl start");
      chk("sda held", 32'h0000_0001, 32'(sda_oe));
      bus(1'b1, IMS_ADR_STAT, 32'h0000_00ff);
      send(1'b0);
      stretch_ns = 10'h258;
      send(1'b1);
      stretch_ns = 10'h000;
      bus(1'b1, IMS_ADR_CTRL, 32'h0000_0002);
      wait_ev(IMS_S_EVENT);
      chk("restart done", EV | SD | AK, q);
      chk("lines low", 32'h0000_0003, 32'({scl_oe, sda_oe}));
      bus(1'b1, IMS_ADR_STAT, 32'h0000_00ff);
      send(1'b0);
      tx_byte = 8'($random(seed));
      rd_mode = 1'b1;
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, IMS_ADR_CTRL, 32'h0000_0008);
         wait_ev(IMS_S_EVENT);
         chk("status recv", EV | BF | (i == 1 ? RO : 32'h0000_0000), q);
         rd(IMS_ADR_CTRL, 32'h0000_0000, "ctrl recv");
         b = tx_byte;
         tx_byte = 8'($random(seed));
         bus(1'b1, IMS_ADR_STAT, 32'h0000_00ff);
         bus(1'b1, IMS_ADR_CTRL, i == 1 ? 32'h0000_0030 : 32'h0000_0010);
         wait_ev(IMS_S_EVENT);
         rd(IMS_ADR_CTRL, i == 1 ? 32'h0000_0020 : 32'h0000_0000, "ctrl ack");
         bus(1'b1, IMS_ADR_STAT, 32'h0000_00ff);
      end
      rd_mode = 1'b0;
      rd(IMS_ADR_BUF, {24'h00_0000, b}, "rx byte");
      rd(IMS_ADR_STAT, 32'h0000_0000, "full cleared");
      bus(1'b1, IMS_ADR_CTRL, 32'h0000_0004);
      bus(1'b1, IMS_ADR_CTRL, 32'h0000_0008);
      rd(IMS_ADR_CTRL, 32'h0000_0004, "ctrl in stop");
      wait_ev(IMS_S_EVENT);
      chk("stop done", EV | PD, q);
      chk("lines free", 32'h0000_0000, 32'({scl_oe, sda_oe}));
      end_of_test();
   end
endmodule : i2c_master_sequencer_test
bind ims_master ims_master_checker checker_u (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire
